// File: rate_pkg.sv
// constants, types and register map of the conversion scheduling block
//
// Functional notes
// - rate codes 0..9 pick 0.05 Hz up to 26 Hz
// - rate codes above nine run at 26 Hz
// - rate register bits 7:4 read as zero
// - standby trigger write runs exactly one conversion
// - trigger data byte ignored, any value starts
// - busy flag high only while converting
package rate_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam logic [31:0] CLK_HZ       = 32'h0EE6B280; // 250 MHz core clock
  localparam logic [31:0] CLK_PERIOD_NS = 32'h00000004; // clock period in ns
  localparam logic [63:0] MHZ_PER_HZ   = 64'h00000000000003E8; // mHz in one Hz
  localparam int          RATE_N       = 10;            // decoded rate steps
  localparam int          PERIOD_W     = 36;            // period counter width
  localparam int          CONV_W       = 16;            // conversion counter width
  localparam logic [15:0] CONV_CYC     = 16'h0040;      // cycles one conversion lasts

  // rates in mHz, code 0 first
  localparam logic [31:0] RATE_MHZ [RATE_N] = '{
    32'h00000032, 32'h00000064, 32'h000000CC, 32'h00000196, 32'h0000032D,
    32'h00000659, 32'h00000CB2, 32'h00001964, 32'h000032C8, 32'h00006590};

  typedef logic [PERIOD_W-1:0] period_tab_t [RATE_N];

  // clock cycles per conversion period for each rate code
  function automatic period_tab_t period_tab();
    period_tab_t t;
    for (int i = 0; i < RATE_N; i++)
    begin
      t[i] = PERIOD_W'((64'(CLK_HZ) * MHZ_PER_HZ) / 64'(RATE_MHZ[i]));
    end
    return t;
  endfunction

  // ****************************************
  // register map: index, byte address is four times it
  // ****************************************
  localparam int          ADDR_W       = 10;     // apb byte address width
  localparam logic [7:0]  IDX_STATUS   = 8'h02;  // busy flag
  localparam logic [7:0]  IDX_RUN_CTRL = 8'h03;  // standby control
  localparam logic [7:0]  IDX_RATE     = 8'h04;  // conversion_rate_select
  localparam logic [7:0]  IDX_RATE_ALT = 8'h0A;  // second address of the same
  localparam logic [7:0]  IDX_TRIG     = 8'h0F;  // single_conversion_trigger
  localparam logic [7:0]  IDX_MAKER    = 8'hFE;  // maker_identifier
  localparam logic [7:0]  IDX_DIE_REV  = 8'hFF;  // die_revision_identifier

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          RATE_FIELD_W = 4;        // rate_select_field width
  localparam logic [3:0]  RATE_CODE_MAX = 4'h9;    // fastest distinct code
  localparam logic [7:0]  RATE_RST     = 8'h08;    // rate register reset
  localparam int          BUSY_BIT     = 7;        // status busy position
  localparam int          STANDBY_BIT  = 6;        // run control standby position
  localparam logic [7:0]  RUN_CTRL_RST = 8'h00;    // converting after reset
  localparam logic [7:0]  MAKER_ID     = 8'h5A;    // arbitrary value
  localparam logic [7:0]  DIE_REV_ID   = 8'hA3;    // arbitrary value

  // ****************************************
  // carriers and state records
  // ****************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [PERIOD_W-1:0] cnt;
    logic                tick;
  } timer_st_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_BUSY = 2'b10
  } eng_state_t;

  typedef struct packed {
    eng_state_t        state;
    logic [CONV_W-1:0] cnt;
    logic              busy;
    logic              start;
  } eng_st_t;

  typedef struct packed {
    logic [RATE_FIELD_W-1:0] rate;
    logic                    standby;
    logic                    pend;
    logic [31:0]             rdata;
    logic                    slverr;
  } regs_st_t;

endpackage

// File: conv_timer.sv
// periodic conversion timer with saturating rate decode
module conv_timer #(
  parameter rate_pkg::period_tab_t PERIOD_CYC = rate_pkg::period_tab()
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  // control
  input  wire logic                              run,
  input  wire logic [rate_pkg::RATE_FIELD_W-1:0] code,
  // period elapsed pulse
  output      logic                              tick
);

  rate_pkg::timer_st_t      st_q;    // registered state
  rate_pkg::timer_st_t      st_d;    // next state
  logic [rate_pkg::PERIOD_W-1:0] period;  // selected period

  // ****************************************
  // rate decode
  // ****************************************
  always_comb
  begin
    if (code > rate_pkg::RATE_CODE_MAX)
      period = PERIOD_CYC[rate_pkg::RATE_N-1];
    else
      period = PERIOD_CYC[code];
  end

  // ****************************************
  // counter
  // ****************************************
  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!run)
      st_d.cnt = '0;  // cleared while in standby
    else if (st_q.cnt >= period - 1'b1)
    begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end
    else
      st_d.cnt = st_q.cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  assign tick = st_q.tick;

  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    (ce && run && st_q.cnt == period - 1'b1) |=> tick)
    else $error("timer did not tick at end of period");

  a_rate_saturate: assert property (@(posedge clk) disable iff (rst)
    (code > rate_pkg::RATE_CODE_MAX) |-> (period == PERIOD_CYC[rate_pkg::RATE_N-1]))
    else $error("rate code above nine not at fastest period");

endmodule

// File: conv_engine.sv
// single conversion sequencer: idle, then busy for a fixed span
module conv_engine (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // request and status
  input  wire logic start_req,
  output      logic busy,
  output      logic start_pulse
);

  rate_pkg::eng_st_t st_q;  // registered state
  rate_pkg::eng_st_t st_d;  // next state

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    st_d       = st_q;
    st_d.start = 1'b0;
    case (st_q.state)
      rate_pkg::ENG_IDLE:
      begin
        if (start_req)
        begin
          st_d.state = rate_pkg::ENG_BUSY;
          st_d.cnt   = '0;
          st_d.busy  = 1'b1;
          st_d.start = 1'b1;
        end
      end
      rate_pkg::ENG_BUSY:
      begin
        if (st_q.cnt == rate_pkg::CONV_CYC - 1'b1)
        begin
          st_d.state = rate_pkg::ENG_IDLE;
          st_d.busy  = 1'b0;
        end
        else
          st_d.cnt = st_q.cnt + 1'b1;
      end
      default:
      begin
        st_d.state = rate_pkg::ENG_IDLE;
        st_d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '{state: rate_pkg::ENG_IDLE, cnt: '0, busy: 1'b0, start: 1'b0};
    else if (ce)
      st_q <= st_d;
  end

  assign busy        = st_q.busy;
  assign start_pulse = st_q.start;

  a_busy_length: assert property (@(posedge clk) disable iff (rst)
    (ce && $fell(busy)) |-> ($past(st_q.cnt) == rate_pkg::CONV_CYC - 1'b1))
    else $error("busy dropped before conversion span ended");

  a_busy_state: assert property (@(posedge clk) disable iff (rst)
    busy |-> (st_q.state == rate_pkg::ENG_BUSY && st_q.cnt < rate_pkg::CONV_CYC))
    else $error("busy flag disagrees with sequencer");

endmodule

// File: conv_rate_ctrl.sv
// conversion scheduling block with apb register slave
//
// The APB slave port is this design's own decision.
module conv_rate_ctrl #(
  parameter rate_pkg::period_tab_t PERIOD_CYC = rate_pkg::period_tab()
) (
  // clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // apb slave
  input  wire rate_pkg::apb_req_t apb_req,
  output      logic [31:0]        prdata,
  output      logic               pready,
  output      logic               pslverr,
  // converter side
  output      logic               conv_start,
  output      logic               conv_busy
);

  // ****************************************
  // state and wires
  // ****************************************
  rate_pkg::regs_st_t st_q;      // registered state
  rate_pkg::regs_st_t st_d;      // next state
  logic [7:0]         idx;       // word index of the access
  logic               setup;     // apb setup cycle
  logic               access;    // apb access cycle
  logic               wr_take;   // write committed this edge
  logic               rd_setup;  // read being prepared
  logic               trig_wr;   // trigger write committed
  logic               tick;      // period elapsed
  logic               eng_busy;  // engine converting
  logic               eng_start; // engine started
  logic               accept;    // pending request handed over
  logic               periodic;  // periodic request this cycle
  logic [7:0]         wbyte;     // low write byte
  logic               mapped;    // index decodes to a register

  // ****************************************
  // apb decode
  // ****************************************
  assign idx      = apb_req.paddr[rate_pkg::ADDR_W-1:2];
  assign setup    = apb_req.psel && !apb_req.penable;
  assign access   = apb_req.psel && apb_req.penable;
  assign wr_take  = access && apb_req.pwrite && ce;
  assign rd_setup = setup && !apb_req.pwrite;
  assign wbyte    = apb_req.pwdata[7:0];

  // zero wait state, answer in the access cycle
  assign pready = access;

  // which indices exist
  always_comb
  begin
    case (idx)
      rate_pkg::IDX_STATUS,
      rate_pkg::IDX_RUN_CTRL,
      rate_pkg::IDX_RATE,
      rate_pkg::IDX_RATE_ALT,
      rate_pkg::IDX_TRIG,
      rate_pkg::IDX_MAKER,
      rate_pkg::IDX_DIE_REV:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // ****************************************
  // conversion requests
  // ****************************************
  // any byte at the trigger index counts as a trigger
  assign trig_wr = wr_take && (idx == rate_pkg::IDX_TRIG);

  // periodic requests only while running
  assign periodic = tick && !st_q.standby;

  // hand the pending request to an idle engine
  assign accept = st_q.pend && !eng_busy;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;

    // register writes
    if (wr_take)
    begin
      case (idx)
        rate_pkg::IDX_RATE,
        rate_pkg::IDX_RATE_ALT:
          st_d.rate = wbyte[rate_pkg::RATE_FIELD_W-1:0];
        rate_pkg::IDX_RUN_CTRL:
          st_d.standby = wbyte[rate_pkg::STANDBY_BIT];
        default:
          st_d.standby = st_q.standby;  // read only, trigger or unmapped
      endcase
    end

    // pending request, a new request wins over the hand-over
    if (accept)
      st_d.pend = 1'b0;
    if (trig_wr && st_q.standby)
      st_d.pend = 1'b1;
    else if (periodic)
      st_d.pend = 1'b1;

    // read data and error prepared in the setup cycle
    if (setup)
    begin
      st_d.rdata  = '0;
      st_d.slverr = !mapped;
      if (rd_setup)
      begin
        case (idx)
          rate_pkg::IDX_STATUS:
            st_d.rdata[rate_pkg::BUSY_BIT] = eng_busy;
          rate_pkg::IDX_RUN_CTRL:
            st_d.rdata[rate_pkg::STANDBY_BIT] = st_q.standby;
          rate_pkg::IDX_RATE,
          rate_pkg::IDX_RATE_ALT:
            st_d.rdata[rate_pkg::RATE_FIELD_W-1:0] = st_q.rate;
          rate_pkg::IDX_MAKER:
            st_d.rdata[7:0] = rate_pkg::MAKER_ID;
          rate_pkg::IDX_DIE_REV:
            st_d.rdata[7:0] = rate_pkg::DIE_REV_ID;
          default:
            st_d.rdata = '0;  // trigger and unmapped read zero
        endcase
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q.rate    <= rate_pkg::RATE_RST[rate_pkg::RATE_FIELD_W-1:0];
      st_q.standby <= rate_pkg::RUN_CTRL_RST[rate_pkg::STANDBY_BIT];
      st_q.pend    <= 1'b0;
      st_q.rdata   <= '0;
      st_q.slverr  <= 1'b0;
    end
    else if (ce)
      st_q <= st_d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata     = st_q.rdata;
  assign pslverr    = st_q.slverr && access;
  assign conv_start = eng_start;
  assign conv_busy  = eng_busy;

  // ****************************************
  // submodules
  // ****************************************
  // period timer, held in standby
  conv_timer #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_timer (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .run  (!st_q.standby),
    .code (st_q.rate),
    .tick (tick)
  );

  // conversion sequencer
  conv_engine u_engine (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .start_req   (accept),
    .busy        (eng_busy),
    .start_pulse (eng_start)
  );

  // ****************************************
  // checks
  // ****************************************
  a_rate_upper_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_setup && (idx == rate_pkg::IDX_RATE || idx == rate_pkg::IDX_RATE_ALT))
      |=> (prdata[31:rate_pkg::RATE_FIELD_W] == '0))
    else $error("rate register upper bits not zero");

  a_trig_sets_pend: assert property (@(posedge clk) disable iff (rst)
    (trig_wr && st_q.standby) |=> st_q.pend)
    else $error("standby trigger did not queue a conversion");

  a_trig_any_data: assert property (@(posedge clk) disable iff (rst)
    (trig_wr && st_q.standby && wbyte == 8'h00) |=> st_q.pend)
    else $error("zero data trigger ignored");

  a_accept_busy: assert property (@(posedge clk) disable iff (rst)
    (ce && accept) |=> (conv_busy && conv_start))
    else $error("accepted request did not start conversion");

  a_run_ignores_trig: assert property (@(posedge clk) disable iff (rst)
    (ce && trig_wr && !st_q.standby && !periodic && !st_q.pend) |=> !st_q.pend)
    else $error("trigger queued while running");

  a_status_busy: assert property (@(posedge clk) disable iff (rst)
    (ce && rd_setup && idx == rate_pkg::IDX_STATUS)
      |=> (prdata[rate_pkg::BUSY_BIT] == $past(eng_busy)))
    else $error("status busy bit wrong");

  a_standby_quiet: assert property (@(posedge clk) disable iff (rst)
    (ce && st_q.standby && !st_q.pend && !trig_wr && !eng_busy) |=> !conv_start)
    else $error("conversion started in standby without trigger");

endmodule

// File: testbench.sv
// self-checking bench of the conversion scheduling block over apb
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals
  // ****************************************
  // shortened periods, code 0 first, all longer than one conversion
  localparam rate_pkg::period_tab_t PER = '{36'h3E8, 36'h384, 36'h320, 36'h2BC, 36'h258,
                                            36'h1F4, 36'h190, 36'h12C, 36'h0C8, 36'h064};
  logic               clk;        // core clock
  logic               rst;        // synchronous reset
  logic               ce;         // clock enable
  rate_pkg::apb_req_t req;        // apb request
  logic [31:0]        prdata;     // read data
  logic               pready;     // transfer end
  logic               pslverr;    // error answer
  logic               conv_start; // start pulse
  logic               conv_busy;  // converting
  logic [31:0]        cyc;        // cycle count
  logic [31:0]        starts;     // start pulses seen
  logic [31:0]        last_t;     // cycle of last start
  logic [31:0]        bcnt;       // running busy length
  logic [31:0]        busy_len;   // last busy length
  logic [31:0]        rdat;       // read result
  logic               rerr;       // error result
  logic [31:0]        t1;         // first start
  logic [31:0]        t2;         // second start
  logic [31:0]        s0;         // start count snapshot
  logic [7:0]         tv [3];     // trigger data values
  int                 n_mismatch; // mismatches
  int                 compares;   // comparisons

  // ****************************************
  // design and clock
  // ****************************************
  conv_rate_ctrl #(.PERIOD_CYC(PER)) dut (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .apb_req    (req),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .conv_start (conv_start),
    .conv_busy  (conv_busy)
  );

  // clock at 4 ns period
  always #2 clk = ~clk;

  // monitor of starts and busy length
  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (conv_start === 1'b1)
    begin
      starts <= starts + 32'h1;
      last_t <= cyc;
    end
    if (conv_busy === 1'b1)
      bcnt <= bcnt + 32'h1;
    else if (bcnt != 32'h0)
    begin
      busy_len <= bcnt;
      bcnt     <= 32'h0;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {idx, 2'b00};
    req.pwdata  <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 50)
      n_mismatch++;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // wait for the next start pulse, bounded
  task automatic wait_start(output logic [31:0] t);
    logic [31:0] snap;
    int          n;
    snap = starts;
    n = 0;
    while (starts === snap && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      n_mismatch++;
    t = last_t;
  endtask

  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  // watchdog
  initial
  begin
    #300000;
    n_mismatch++;
    results();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    req = '0;
    cyc = 32'h0;
    starts = 32'h0;
    last_t = 32'h0;
    bcnt = 32'h0;
    busy_len = 32'h0;
    tv = '{8'h00, 8'hA5, 8'hFF};
    n_mismatch = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset value and identification words
    apb(1'b0, rate_pkg::IDX_RATE, 32'h0);
    chk("rate reset", rdat, 32'h00000008);
    apb(1'b1, rate_pkg::IDX_MAKER, 32'h000000FF);
    apb(1'b0, rate_pkg::IDX_MAKER, 32'h0);
    chk("maker id", rdat, {24'h0, rate_pkg::MAKER_ID});
    apb(1'b0, rate_pkg::IDX_DIE_REV, 32'h0);
    chk("die rev id", rdat, {24'h0, rate_pkg::DIE_REV_ID});
    // unmapped index answers with error
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped err", rerr, 1'b1);
    chk("unmapped data", rdat, 32'h0);
    // upper rate bits read zero at both addresses
    apb(1'b1, rate_pkg::IDX_RATE, 32'h000000F7);
    apb(1'b0, rate_pkg::IDX_RATE, 32'h0);
    chk("rate upper", rdat, 32'h00000007);
    apb(1'b0, rate_pkg::IDX_RATE_ALT, 32'h0);
    chk("rate alias", rdat, 32'h00000007);
    // every rate code, interval between periodic starts
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, rate_pkg::IDX_RATE, 32'(c));
      wait_start(t1);
      wait_start(t1);
      wait_start(t2);
      chk("rate period", 36'(t2 - t1), PER[(c > 9) ? 9 : c]);
      chk("busy length", busy_len, 32'(rate_pkg::CONV_CYC));
    end
    // standby: no periodic starts
    apb(1'b1, rate_pkg::IDX_RUN_CTRL, 32'h00000040);
    repeat (100) @(posedge clk);
    s0 = starts;
    repeat (1100) @(posedge clk);
    chk("standby idle", starts, s0);
    // each trigger value runs exactly one conversion
    for (int i = 0; i < 3; i++)
    begin
      s0 = starts;
      apb(1'b1, rate_pkg::IDX_TRIG, {24'hFFFFFF, tv[i]});
      repeat (4) @(posedge clk);
      apb(1'b0, rate_pkg::IDX_STATUS, 32'h0);
      chk("busy during", rdat[rate_pkg::BUSY_BIT], 1'b1);
      repeat (100) @(posedge clk);
      chk("one shot", starts, s0 + 32'h1);
      chk("shot length", busy_len, 32'(rate_pkg::CONV_CYC));
      apb(1'b0, rate_pkg::IDX_STATUS, 32'h0);
      chk("busy after", rdat[rate_pkg::BUSY_BIT], 1'b0);
    end
    // clock enable low freezes a running conversion
    apb(1'b1, rate_pkg::IDX_TRIG, 32'h00000011);
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    chk("ce freeze", conv_busy, 1'b1);
    ce <= 1'b1;
    repeat (100) @(posedge clk);
    chk("ce resume", conv_busy, 1'b0);
    // running mode ignores the trigger
    apb(1'b1, rate_pkg::IDX_RATE, 32'h0);
    apb(1'b1, rate_pkg::IDX_RUN_CTRL, 32'h0);
    wait_start(t1);
    s0 = starts;
    apb(1'b1, rate_pkg::IDX_TRIG, 32'h0000005A);
    repeat (300) @(posedge clk);
    chk("trigger ignored", starts, s0);
    results();
  end

endmodule
